// file: fds_params.svh
// register map, field positions, reset values and timing counts for the floppy buffer
`ifndef FDS_PARAMS_SVH
`define FDS_PARAMS_SVH

// byte offsets of the registers
`define FDS_OFF_CTRL 8'h00
`define FDS_OFF_SETUP 8'h04
`define FDS_OFF_TIMING 8'h08
`define FDS_OFF_DRIVE 8'h0C
`define FDS_OFF_CFG6 8'h10
`define FDS_OFF_MSR 8'h14
`define FDS_OFF_STAT 8'h18
`define FDS_OFF_DATA 8'h1C

// control register bits (write-only pulses)
`define FDS_CTRL_START 0
`define FDS_CTRL_READ 1
`define FDS_CTRL_VERIFY 2
`define FDS_CTRL_END 3

// setup-options register fields
`define FDS_SETUP_FIFO_EN 0
`define FDS_SETUP_THR_LSB 4
`define FDS_SETUP_RST 8'h00

// timing-setup register fields
`define FDS_TIM_DMA_EN 0
`define FDS_TIM_RATE_LSB 1
`define FDS_TIM_RST 8'h00
`define FDS_RATE_2M 2'h3
`define FDS_RATE_1M 2'h2

// drive control register fields
`define FDS_DRV_MOTOR_FIRST 0
`define FDS_DRV_MOTOR_SECOND 1
`define FDS_DRV_SEL_FIRST 2
`define FDS_DRV_SEL_SECOND 3
`define FDS_DRV_DIR_OUT 4
`define FDS_DRV_STEP 5
`define FDS_DRV_RST 8'h10

// configuration register six fields
`define FDS_CFG6_MODE_LSB 0
`define FDS_CFG6_PULLUP_OFF 4
`define FDS_CFG6_RST 8'h00

// main status register bits
`define FDS_MSR_BUSY 4
`define FDS_MSR_EXEC 5
`define FDS_MSR_DIO 6
`define FDS_MSR_RQM 7

// status register fields
`define FDS_STAT_OVR 5
`define FDS_STAT_UNR 6
`define FDS_STAT_CNT_LSB 8

// bus responses
`define FDS_RESP_OKAY 2'h0
`define FDS_RESP_SLVERR 2'h2

// step pulse width
`define FDS_CLK_MHZ 40
`define FDS_STEP_NS 1000
`define FDS_STEP_CYC ((`FDS_STEP_NS * `FDS_CLK_MHZ + 999) / 1000)

`endif

// file: fds_pkg.sv
// types shared by the floppy buffer and drive signalling block
package fds_pkg;

  // command phase of the controller
  typedef enum logic [1:0] {
    FDS_CMD = 2'b00,
    FDS_EXEC = 2'b01,
    FDS_RESULT = 2'b10
  } fds_phase_e;

  // host compatibility modes
  typedef enum logic [1:0] {
    FDS_MODE_AT = 2'b00,
    FDS_MODE_M30 = 2'b01,
    FDS_MODE_EXT = 2'b10
  } fds_mode_e;

  // open-drain drive control pins
  typedef struct packed {
    logic step;
    logic dir;
    logic motor_on_first;
    logic motor_on_second;
    logic drive_select_first;
    logic drive_select_second;
  } fds_drive_s;

  // drive status pins, as sampled (active low on the wire)
  typedef struct packed {
    logic read_data;
    logic media_changed_in;
    logic media_protect;
    logic outer_track_flag;
    logic track_start;
  } fds_sense_s;

endpackage : fds_pkg

// file: fds_floppy_fifo.sv
// floppy data buffer, dma pacing and drive-side pins behind an axi4-lite slave
`include "fds_params.svh"

module fds_floppy_fifo
  import fds_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int STEP_CYC = `FDS_STEP_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // dma pins, active low strobes
  input wire logic i_dack_n,
  input wire logic i_dma_rd_n,
  input wire logic i_dma_wr_n,
  input wire logic [7:0] i_dma_data,
  output logic [7:0] o_dma_data,
  output logic o_dma_data_oe,
  output logic o_drq,
  // disk-side byte stream from the controller core
  input wire logic i_dsk_push,
  input wire logic [7:0] i_dsk_data,
  input wire logic i_dsk_pop,
  output logic [7:0] o_dsk_data,
  output logic o_dsk_fill,
  output logic o_terminate,
  // drive pins
  input wire fds_sense_s i_sense,
  input wire logic i_fast_ref,
  output fds_drive_s o_drv_out,
  output fds_drive_s o_drv_oe,
  output logic o_pullup_en,
  output logic [1:0] o_rate_sel
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int SYN = 16;

  // pin synchronisers: three stages, filtered value moves when stages two and three agree
  logic [SYN-1:0] pin_raw;
  logic [SYN-1:0] s1_reg;
  logic [SYN-1:0] s2_reg;
  logic [SYN-1:0] s3_reg;
  logic [SYN-1:0] filt_reg;
  assign pin_raw = {i_dma_data, i_sense, i_dack_n, i_dma_rd_n, i_dma_wr_n};
  for (genvar g = 0; g < SYN; g++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        s1_reg[g] <= 1'b1;
        s2_reg[g] <= 1'b1;
        s3_reg[g] <= 1'b1;
        filt_reg[g] <= 1'b1;
      end else begin
        s1_reg[g] <= pin_raw[g];
        s2_reg[g] <= s1_reg[g];
        s3_reg[g] <= s2_reg[g];
        if (s2_reg[g] == s3_reg[g]) begin
          filt_reg[g] <= s3_reg[g];
        end
      end
    end
  end

  // named views of the filtered pins
  wire [7:0] dma_data_f = filt_reg[15:8];
  wire fds_sense_s sense_f = filt_reg[7:3];
  wire dack_f = filt_reg[2];
  wire rd_f = filt_reg[1];
  wire wr_f = filt_reg[0];
  logic [2:0] dma_prev_reg;

  // control registers
  fds_phase_e phase_reg;
  logic read_dir_reg;
  logic verify_reg;
  logic [7:0] setup_reg;
  logic [7:0] timing_reg;
  logic [7:0] drive_reg;
  logic [7:0] cfg6_reg;
  logic ovr_reg;
  logic unr_reg;
  logic [$clog2(STEP_CYC+1)-1:0] step_cnt_reg;

  // buffer storage and pointers
  logic [7:0] mem_reg [DEPTH];
  logic [PW-1:0] rd_ptr_reg;
  logic [PW-1:0] wr_ptr_reg;
  logic [CW-1:0] count_reg;

  // axi state
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;

  // buffer capacity: one byte in byte mode, full depth when enabled
  wire fifo_en = setup_reg[`FDS_SETUP_FIFO_EN];
  wire [CW-1:0] cap = fifo_en ? CW'(DEPTH) : CW'(1);
  wire full = count_reg >= cap;
  wire empty = count_reg == '0;
  wire [7:0] head = mem_reg[rd_ptr_reg];
  wire [CW-1:0] free = cap - count_reg;
  wire [CW-1:0] thr = CW'(setup_reg[7:`FDS_SETUP_THR_LSB]) + CW'(1);

  // transfer direction and request-for-master flags
  wire transfer_direction_flag = (phase_reg == FDS_EXEC) ? read_dir_reg : (phase_reg == FDS_RESULT);
  wire request_for_master_flag = transfer_direction_flag ? !empty : !full;
  wire exec = phase_reg == FDS_EXEC;
  wire dma_en = timing_reg[`FDS_TIM_DMA_EN];

  // axi write decode; address and data may arrive in either order
  wire aw_fire = i_awvalid && o_awready;
  wire w_fire = i_wvalid && o_wready;
  wire wr_go = aw_held_reg && w_held_reg && !o_bvalid;
  wire wr_en = wr_go && wstrb0_reg;
  wire wr_ctrl = wr_en && awaddr_reg == `FDS_OFF_CTRL;
  wire wr_setup = wr_en && awaddr_reg == `FDS_OFF_SETUP;
  wire wr_timing = wr_en && awaddr_reg == `FDS_OFF_TIMING;
  wire wr_drive = wr_en && awaddr_reg == `FDS_OFF_DRIVE;
  wire wr_cfg6 = wr_en && awaddr_reg == `FDS_OFF_CFG6;
  wire wr_data = wr_en && awaddr_reg == `FDS_OFF_DATA;
  wire wr_mapped = awaddr_reg[7:5] == 3'h0 && awaddr_reg[1:0] == 2'h0
    && awaddr_reg != `FDS_OFF_MSR && awaddr_reg != `FDS_OFF_STAT;
  wire start = wr_ctrl && wdata_reg[`FDS_CTRL_START];
  wire end_req = wr_ctrl && wdata_reg[`FDS_CTRL_END];

  // axi read decode
  wire ar_fire = i_arvalid && o_arready;
  wire rd_mapped = i_araddr[7:5] == 3'h0 && i_araddr[1:0] == 2'h0;
  wire rd_data = ar_fire && i_araddr == `FDS_OFF_DATA;

  // host byte moves only when the flags allow it
  wire host_push = wr_data && request_for_master_flag && !transfer_direction_flag;
  wire host_pop = rd_data && request_for_master_flag && transfer_direction_flag;

  // dma strobes act on acknowledge alone, no address is looked at
  wire dack_act = !dack_f;
  wire rd_fall = dma_prev_reg[1] && !rd_f;
  wire wr_fall = dma_prev_reg[0] && !wr_f;
  wire dack_fall = dma_prev_reg[2] && dack_act;
  wire dma_pop = dack_act && rd_fall && transfer_direction_flag;
  wire dma_push = dack_act && wr_fall && !transfer_direction_flag;
  wire pseudo_pop = dack_fall && verify_reg && !fifo_en && read_dir_reg && exec;

  // disk side: overrun on a read, underrun on a write
  wire dsk_pop_ok = i_dsk_pop && !empty;
  wire ovr_set = i_dsk_push && full && exec && read_dir_reg;
  wire unr_set = i_dsk_pop && empty && exec && !read_dir_reg;

  // one push and one pop per cycle at most
  wire push_req = host_push || dma_push || i_dsk_push;
  wire push = push_req && !full;
  wire pop = (host_pop || dma_pop || pseudo_pop || dsk_pop_ok) && !empty;
  wire [7:0] push_data = host_push ? wdata_reg[7:0] : dma_push ? dma_data_f : i_dsk_data;

  // dma request level: threshold with buffer on, single byte in byte mode
  wire drq_read = fifo_en ? (count_reg >= thr) : !empty;
  wire drq_write = fifo_en ? (free >= thr) : !full;
  wire check_no_dma = verify_reg && fifo_en;
  wire drq_next = exec && dma_en && !check_no_dma && (read_dir_reg ? drq_read : drq_write);

  // requested data rate, 2 Mbit/s only with the fast reference
  wire [1:0] rate_req = timing_reg[`FDS_TIM_RATE_LSB +: 2];
  wire [1:0] rate_next = (rate_req == `FDS_RATE_2M && !i_fast_ref) ? `FDS_RATE_1M : rate_req;

  // read mux; the basic mode hides the buffer count
  wire fds_mode_e mode = fds_mode_e'(cfg6_reg[`FDS_CFG6_MODE_LSB +: 2]);
  wire [4:0] sense_act = ~sense_f;
  wire [CW-1:0] cnt_view = (mode == FDS_MODE_AT) ? '0 : count_reg;
  wire [7:0] msr = {request_for_master_flag, transfer_direction_flag, exec && !dma_en, phase_reg != FDS_CMD, 4'h0};
  wire [31:0] stat = {{(32 - `FDS_STAT_CNT_LSB - CW){1'b0}}, cnt_view, 1'b0,
    unr_reg, ovr_reg, sense_act};
  logic [31:0] rd_word;
  always_comb begin
    case (i_araddr)
      `FDS_OFF_SETUP: rd_word = {24'h0, setup_reg};
      `FDS_OFF_TIMING: rd_word = {24'h0, timing_reg};
      `FDS_OFF_DRIVE: rd_word = {24'h0, drive_reg};
      `FDS_OFF_CFG6: rd_word = {24'h0, cfg6_reg};
      `FDS_OFF_MSR: rd_word = {24'h0, msr};
      `FDS_OFF_STAT: rd_word = stat;
      `FDS_OFF_DATA: rd_word = {24'h0, head};
      default: rd_word = 32'h0;
    endcase
  end

  // axi write channel handshakes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `FDS_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        o_awready <= 1'b0;
        aw_held_reg <= 1'b1;
        awaddr_reg <= i_awaddr;
      end
      if (w_fire) begin
        o_wready <= 1'b0;
        w_held_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb0_reg <= i_wstrb[0];
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_mapped ? `FDS_RESP_OKAY : `FDS_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // axi read channel; a data read pops at the address handshake
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= `FDS_RESP_OKAY;
    end else if (ar_fire) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_mapped ? `FDS_RESP_OKAY : `FDS_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // software registers; the buffer enable only moves on a reset or a setup-options write
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      setup_reg <= `FDS_SETUP_RST;
      timing_reg <= `FDS_TIM_RST;
      drive_reg <= `FDS_DRV_RST;
      cfg6_reg <= `FDS_CFG6_RST;
    end else begin
      if (wr_setup) setup_reg <= wdata_reg[7:0];
      if (wr_timing) timing_reg <= wdata_reg[7:0];
      if (wr_drive) drive_reg <= wdata_reg[7:0];
      if (wr_cfg6) cfg6_reg <= wdata_reg[7:0];
    end
  end

  // phase sequencing; errors force the result phase so the host can drain
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase_reg <= FDS_CMD;
      read_dir_reg <= 1'b0;
      verify_reg <= 1'b0;
    end else begin
      case (phase_reg)
        FDS_CMD: begin
          if (start) begin
            phase_reg <= FDS_EXEC;
            read_dir_reg <= wdata_reg[`FDS_CTRL_READ];
            verify_reg <= wdata_reg[`FDS_CTRL_VERIFY];
          end
        end
        FDS_EXEC: begin
          if (ovr_set || unr_set || end_req) phase_reg <= FDS_RESULT;
        end
        FDS_RESULT: begin
          if (end_req) phase_reg <= FDS_CMD;
        end
        default: phase_reg <= FDS_CMD;
      endcase
    end
  end

  // sticky error flags: an error in the clearing cycle still sets
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovr_reg <= 1'b0;
      unr_reg <= 1'b0;
      o_terminate <= 1'b0;
    end else begin
      ovr_reg <= ovr_set || (ovr_reg && !start);
      unr_reg <= unr_set || (unr_reg && !start);
      o_terminate <= ovr_set || unr_set;
    end
  end

  // buffer pointers; entering execution drops stale bytes
  always_ff @(posedge i_clk) begin
    if (i_rst || start) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop) rd_ptr_reg <= rd_ptr_reg + PW'(1);
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end

  // byte storage; data needs no reset
  always_ff @(posedge i_clk) begin
    if (push) mem_reg[wr_ptr_reg] <= push_data;
  end

  // disk byte out; an underrun hands the core zero fill until restart
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dsk_data <= 8'h00;
      o_dsk_fill <= 1'b0;
    end else begin
      if (unr_set || (unr_reg && i_dsk_pop)) begin
        o_dsk_data <= 8'h00;
      end else if (dsk_pop_ok) begin
        o_dsk_data <= head;
      end
      o_dsk_fill <= unr_set || (unr_reg && !start);
    end
  end

  // dma data bus and request; edges are taken on the filtered strobes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dma_prev_reg <= 3'h7;
      o_dma_data <= 8'h00;
      o_dma_data_oe <= 1'b0;
      o_drq <= 1'b0;
    end else begin
      dma_prev_reg <= {dack_f, rd_f, wr_f};
      if (dma_pop) o_dma_data <= head;
      o_dma_data_oe <= dack_act && !rd_f && transfer_direction_flag;
      o_drq <= drq_next;
    end
  end

  // step pulse timer, restarted by each step request
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      step_cnt_reg <= '0;
    end else if (wr_drive && wdata_reg[`FDS_DRV_STEP]) begin
      step_cnt_reg <= ($clog2(STEP_CYC+1))'(STEP_CYC);
    end else if (step_cnt_reg != '0) begin
      step_cnt_reg <= step_cnt_reg - 1'b1;
    end
  end

  // open-drain pins: the level is always low, the enable pulls the wire
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_drv_out <= '0;
      o_drv_oe <= '0;
      o_pullup_en <= 1'b1;
      o_rate_sel <= 2'h0;
    end else begin
      o_drv_out <= '0;
      o_drv_oe.step <= step_cnt_reg != '0;
      o_drv_oe.dir <= !drive_reg[`FDS_DRV_DIR_OUT];
      o_drv_oe.motor_on_first <= drive_reg[`FDS_DRV_MOTOR_FIRST];
      o_drv_oe.motor_on_second <= drive_reg[`FDS_DRV_MOTOR_SECOND];
      o_drv_oe.drive_select_first <= drive_reg[`FDS_DRV_SEL_FIRST];
      o_drv_oe.drive_select_second <= drive_reg[`FDS_DRV_SEL_SECOND];
      o_pullup_en <= !cfg6_reg[`FDS_CFG6_PULLUP_OFF];
      o_rate_sel <= rate_next;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence step_req_s;
    wr_drive && wdata_reg[`FDS_DRV_STEP];
  endsequence
  sequence step_low_s;
    o_drv_oe.step [*8];
  endsequence

  a_step_pulse_low: assert property (step_req_s |-> ##2 step_low_s)
    else $error("step pulse not held low");
  a_outer_track_seen: assert property ($fell(filt_reg[4]) |=> stat[1])
    else $error("outer track flag not reported");
  a_pullup_follow: assert property (o_pullup_en == !$past(cfg6_reg[4]))
    else $error("pullup enable does not follow setting");
  a_motor_first_on: assert property (o_drv_oe.motor_on_first == $past(drive_reg[0]))
    else $error("motor output mismatch");
  a_fifo_depth_cap: assert property (count_reg <= CW'(DEPTH))
    else $error("buffer count beyond depth");
  a_enable_by_setup: assert property ($changed(setup_reg) |-> $past(wr_setup))
    else $error("buffer setup changed without setup write");
  a_exec_flush: assert property (start |=> count_reg == '0)
    else $error("buffer not flushed on execution");
  a_error_terminates: assert property ((ovr_set || unr_set) |=> phase_reg == FDS_RESULT
    && o_terminate)
    else $error("error did not end the command");
  a_underrun_zero: assert property (unr_set |=> o_dsk_data == 8'h00 && o_dsk_fill)
    else $error("underrun fill not zero");
  a_drq_needs_dma: assert property (o_drq |-> $past(dma_en) && $past(exec))
    else $error("dma request without dma enabled");
  a_dir_outward: assert property (drive_reg[4] |=> !o_drv_oe.dir)
    else $error("direction pin not released for outward motion");

endmodule : fds_floppy_fifo

// file: fds_dma_model.sv
// dma controller model that answers the block's transfer requests
module fds_dma_model (
  // clock
  input wire logic i_clk,
  // request from the block and the byte it presents
  input wire logic i_drq,
  input wire logic [7:0] i_rdata,
  // acknowledge, active low strobes and the write byte
  output logic o_dack_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus: everything released
  initial begin
    o_dack_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_data = 8'hA5;
  end

  // one byte per call; strobes held well past the block's pin filter
  // need_req low continues a burst that an earlier request opened
  task automatic xfer(input logic dir_wr, input logic [7:0] wd, input int gap,
                      input logic need_req, output logic [7:0] rb);
    while (need_req && i_drq !== 1'b1) @(posedge i_clk);
    o_dack_n <= 1'b0;
    if (dir_wr) o_data <= wd;
    repeat (2 + gap) @(posedge i_clk);
    if (dir_wr) o_wr_n <= 1'b0;
    else o_rd_n <= 1'b0;
    repeat (9) @(posedge i_clk);
    rb = i_rdata;
    o_rd_n <= 1'b1;
    o_wr_n <= 1'b1;
    repeat (7) @(posedge i_clk);
    o_dack_n <= 1'b1;
    o_data <= ~o_data; // released bus must not keep the old byte
    repeat (7 + gap) @(posedge i_clk);
  endtask : xfer

  // verify-mode cycle: acknowledge alone, no strobe and no data
  task automatic pseudo();
    while (i_drq !== 1'b1) @(posedge i_clk);
    o_dack_n <= 1'b0;
    repeat (9) @(posedge i_clk);
    o_dack_n <= 1'b1;
    repeat (9) @(posedge i_clk);
  endtask : pseudo
endmodule : fds_dma_model

// file: fds_floppy_fifo_bench.sv
// self-checking bench for the floppy buffer and drive signalling block
`include "fds_params.svh"
module fds_floppy_fifo_bench
  import fds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 8;
  logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_fast_ref;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_dma_data_oe, o_drq;
  logic i_dack_n, i_dma_rd_n, i_dma_wr_n, i_dsk_push, i_dsk_pop, o_dsk_fill;
  logic o_terminate, o_pullup_en;
  logic [7:0] i_awaddr, i_araddr, o_dma_data, i_dma_data, i_dsk_data, o_dsk_data;
  logic [31:0] i_wdata, o_rdata, rv;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, o_rate_sel;
  fds_sense_s i_sense;
  fds_drive_s o_drv_out, o_drv_oe;
  int n_fail = 0;
  int num_checks = 0;
  int n_term = 0;
  int n_oe = 0;

  fds_floppy_fifo #(.STEP_CYC(STEP)) dut (
    .i_clk, .i_rst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
    .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_dack_n, .i_dma_rd_n, .i_dma_wr_n,
    .i_dma_data, .o_dma_data, .o_dma_data_oe, .o_drq, .i_dsk_push, .i_dsk_data,
    .i_dsk_pop, .o_dsk_data, .o_dsk_fill, .o_terminate, .i_sense, .i_fast_ref,
    .o_drv_out, .o_drv_oe, .o_pullup_en, .o_rate_sel
  );

  fds_dma_model dma (.i_clk, .i_drq(o_drq), .i_rdata(o_dma_data), .o_dack_n(i_dack_n),
    .o_rd_n(i_dma_rd_n), .o_wr_n(i_dma_wr_n), .o_data(i_dma_data));

  // clock and terminate pulse counter
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (o_terminate === 1'b1) n_term <= n_term + 1;
  always @(posedge i_clk) if (o_dma_data_oe === 1'b1) n_oe <= n_oe + 1;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // axi4-lite write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    @(posedge i_clk);
    while (i_awvalid || i_wvalid) begin
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      @(posedge i_clk);
    end
    i_bready <= 1'b1;
    do @(posedge i_clk); while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    chk("bresp", 32'(o_bresp), 32'(er));
    repeat (2) @(posedge i_clk); // let registered pin outputs follow
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    rv = o_rdata;
    chk("rresp", 32'(o_rresp), 32'(er));
  endtask : rd

  // disk-side byte stream, one byte per cycle
  task automatic push(input logic [7:0] b, input int n);
    for (int k = 0; k < n; k++) begin
      i_dsk_push <= 1'b1;
      i_dsk_data <= b + 8'(k);
      @(posedge i_clk);
    end
    i_dsk_push <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : push

  task automatic pop(output logic [7:0] b);
    i_dsk_pop <= 1'b1;
    @(posedge i_clk);
    i_dsk_pop <= 1'b0;
    @(posedge i_clk);
    b = o_dsk_data;
    repeat (2) @(posedge i_clk);
  endtask : pop

  task automatic t_reset();
    chk("drive oe", 32'(o_drv_oe), 32'h0);
    chk("drq", 32'(o_drq), 32'h0);
    rd(`FDS_OFF_SETUP, 2'h0);
    chk("setup", rv, 32'h0);
    rd(8'h20, `FDS_RESP_SLVERR);
    wr(`FDS_OFF_MSR, 32'h0, `FDS_RESP_SLVERR);
    // a parameter byte goes in only once the flags ask for it
    rd(`FDS_OFF_MSR, 2'h0);
    chk("msr idle", rv, 32'h80);
    wr(`FDS_OFF_DATA, 32'h5C, 2'h0);
    rd(`FDS_OFF_MSR, 2'h0);
    chk("msr full", rv, 32'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_drive();
    int k;
    k = 0;
    for (int i = 0; i < 4; i++) begin
      wr(`FDS_OFF_DRIVE, 32'h10 | (32'h1 << i), 2'h0);
      chk("drive pin", 32'(o_drv_oe), 32'h8 >> i);
    end
    wr(`FDS_OFF_DRIVE, 32'h0, 2'h0);
    chk("dir inward", 32'(o_drv_oe), 32'h10);
    chk("drive level", 32'(o_drv_out), 32'h0);
    fork
      wr(`FDS_OFF_DRIVE, 32'h30, 2'h0);
      repeat (40) begin
        @(posedge i_clk);
        if (o_drv_oe.step === 1'b1) k++;
      end
    join
    chk("step width", 32'(k), 32'(STEP));
    wr(`FDS_OFF_CFG6, 32'h12, 2'h0);
    chk("pullup", 32'(o_pullup_en), 32'h0);
    wr(`FDS_OFF_CFG6, 32'h02, 2'h0); // extended mode keeps the count readable
    chk("pullup", 32'(o_pullup_en), 32'h1);
    $display("test drive done");
  endtask : t_drive

  task automatic t_sense();
    for (int i = 0; i < 2; i++) begin
      i_sense <= (i == 1) ? 5'b01001 : 5'b10110;
      repeat (8) @(posedge i_clk);
      rd(`FDS_OFF_STAT, 2'h0);
      chk("sense", {27'h0, rv[4:0]}, (i == 1) ? 32'h16 : 32'h09);
      i_fast_ref <= i[0];
      wr(`FDS_OFF_TIMING, 32'h06, 2'h0);
      chk("rate", 32'(o_rate_sel), (i == 1) ? 32'h3 : 32'h2);
    end
    $display("test sense done");
  endtask : t_sense

  task automatic t_read();
    logic [7:0] b;
    int t0;
    wr(`FDS_OFF_SETUP, 32'h31, 2'h0);
    wr(`FDS_OFF_TIMING, 32'h01, 2'h0);
    wr(`FDS_OFF_CTRL, 32'h03, 2'h0);
    push(8'hA0, 3);
    chk("drq below", 32'(o_drq), 32'h0);
    push(8'hA3, 1);
    chk("drq at", 32'(o_drq), 32'h1);
    // request drops below the threshold, so only the first byte waits for it
    for (int i = 0; i < 4; i++) begin
      dma.xfer(1'b0, 8'h00, i, i == 0, b);
      chk("dma byte", 32'(b), 32'hA0 + 32'(i));
      chk("drq after pop", 32'(o_drq), 32'h0);
    end
    chk("drq empty", 32'(o_drq), 32'h0);
    // bus driven for nine filtered strobe cycles per byte
    chk("dma oe cycles", 32'(n_oe), 32'h24);
    push(8'hB0, 2);
    rd(`FDS_OFF_STAT, 2'h0);
    chk("count", 32'(rv[12:8]), 32'h2);
    wr(`FDS_OFF_CTRL, 32'h08, 2'h0);
    wr(`FDS_OFF_CTRL, 32'h08, 2'h0);
    wr(`FDS_OFF_CTRL, 32'h03, 2'h0);
    rd(`FDS_OFF_STAT, 2'h0);
    chk("flushed", 32'(rv[12:8]), 32'h0);
    t0 = n_term;
    push(8'hC0, 17);
    chk("overrun end", 32'(n_term - t0), 32'h1);
    rd(`FDS_OFF_STAT, 2'h0);
    chk("overrun flag", 32'(rv[5]), 32'h1);
    // host drains what the overrun left behind
    for (int i = 0; i < 16; i++) begin
      rd(`FDS_OFF_DATA, 2'h0);
      chk("drain byte", rv, 32'hC0 + 32'(i));
    end
    $display("test read done");
  endtask : t_read

  task automatic t_write();
    logic [7:0] b;
    int t0;
    wr(`FDS_OFF_CTRL, 32'h08, 2'h0);
    wr(`FDS_OFF_CTRL, 32'h01, 2'h0);
    for (int i = 0; i < 2; i++) dma.xfer(1'b1, 8'h5A + 8'(i), 0, 1'b1, b);
    for (int i = 0; i < 2; i++) begin
      pop(b);
      chk("disk byte", 32'(b), 32'h5A + 32'(i));
    end
    t0 = n_term;
    pop(b);
    chk("fill", 32'(o_dsk_fill), 32'h1);
    chk("underrun end", 32'(n_term - t0), 32'h1);
    rd(`FDS_OFF_STAT, 2'h0);
    chk("underrun flag", 32'(rv[6]), 32'h1);
    $display("test write done");
  endtask : t_write

  task automatic t_verify();
    wr(`FDS_OFF_CTRL, 32'h08, 2'h0);
    wr(`FDS_OFF_CTRL, 32'h07, 2'h0);
    push(8'h70, 4);
    chk("check no drq", 32'(o_drq), 32'h0);
    wr(`FDS_OFF_CTRL, 32'h08, 2'h0);
    wr(`FDS_OFF_CTRL, 32'h08, 2'h0);
    wr(`FDS_OFF_SETUP, 32'h00, 2'h0);
    wr(`FDS_OFF_CTRL, 32'h07, 2'h0);
    push(8'h77, 1);
    chk("byte drq", 32'(o_drq), 32'h1);
    dma.pseudo();
    rd(`FDS_OFF_STAT, 2'h0);
    chk("pseudo pop", 32'(rv[12:8]), 32'h0);
    $display("test verify done");
  endtask : t_verify

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // watchdog: tests need well under this span
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    $display("watchdog expired");
    wrap_up();
  end

  // main sequence
  initial begin
    i_rst = 1'b1;
    i_awvalid = 1'b0;
    i_wvalid = 1'b0;
    i_bready = 1'b0;
    i_arvalid = 1'b0;
    i_rready = 1'b0;
    i_awaddr = 8'h00;
    i_araddr = 8'h00;
    i_wdata = 32'h0;
    i_wstrb = 4'hF;
    i_dsk_push = 1'b0;
    i_dsk_pop = 1'b0;
    i_dsk_data = 8'h00;
    i_sense = 5'h1F;
    i_fast_ref = 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_drive();
    t_sense();
    t_read();
    t_write();
    t_verify();
    // second reset in mid-run: the buffer must come back disabled
    wr(`FDS_OFF_SETUP, 32'h31, 2'h0);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd(`FDS_OFF_SETUP, 2'h0);
    chk("setup after reset", rv, 32'h0);
    wrap_up();
  end
endmodule : fds_floppy_fifo_bench
